/* File: iosic_params.svh */
`ifndef IOSIC_PARAMS_SVH
`define IOSIC_PARAMS_SVH

// Instruction word fields
`define IOSIC_OP_HI 23
`define IOSIC_OP_LO 18
`define IOSIC_SUB_HI 17
`define IOSIC_SUB_LO 15
`define IOSIC_SUB2_HI 14
`define IOSIC_SUB2_LO 12
`define IOSIC_CH_HI 13
`define IOSIC_CH_LO 12
`define IOSIC_CODE_HI 11
`define IOSIC_CODE_LO 0

// Group code and subcodes
`define IOSIC_GROUP 6'h3F
`define IOSIC_SUB_CON 3'h0
`define IOSIC_SUB_SEL 3'h1
`define IOSIC_SUB_EXT 3'h2
`define IOSIC_SUB_INT 3'h3
`define IOSIC_SUB_SENSE 3'h4
`define IOSIC_SUB_G5 3'h5
`define IOSIC_SUB_G7 3'h7
`define IOSIC_G5_CLEAR 3'h0
`define IOSIC_G5_MSET 3'h2
`define IOSIC_G5_MCLR 3'h3
`define IOSIC_G5_PEER 3'h7
`define IOSIC_G7_FLOAT 3'h1
`define IOSIC_G7_DEC 3'h2
`define IOSIC_G7_OFF 3'h3
`define IOSIC_G7_ON 3'h4

// Interrupt bit positions
`define IOSIC_BIT_CLOCK 8
`define IOSIC_BIT_EXP 9
`define IOSIC_BIT_ARITH 10
`define IOSIC_BIT_SEARCH 11

// Reset values and return offsets
`define IOSIC_MASK_RST 12'h000
`define IOSIC_OFS_NEXT 2'h1
`define IOSIC_OFS_SKIP 2'h2

`endif

/* File: iosic_pkg.sv */
package iosic_pkg;
    typedef enum logic [3:0] {
        IOSIC_OP_NONE,
        IOSIC_OP_CON,
        IOSIC_OP_SEL,
        IOSIC_OP_EXT_COPY,
        IOSIC_OP_EXT_PROBE,
        IOSIC_OP_INT_COPY,
        IOSIC_OP_INT_PROBE,
        IOSIC_OP_INT_SENSE,
        IOSIC_OP_FLAG_CLEAR,
        IOSIC_OP_MSET,
        IOSIC_OP_MCLR,
        IOSIC_OP_PEER,
        IOSIC_OP_FLOAT,
        IOSIC_OP_DEC,
        IOSIC_OP_GATE_OFF,
        IOSIC_OP_GATE_ON
    } iosic_op_t;
endpackage

/* File: iosic_busy.sv */
`timescale 1ns/1ps
module iosic_busy (
    // Clock and control
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Channel activity
    input wire logic [3:0] i_writing,
    input wire logic [3:0] i_reading,
    input wire logic [3:0] i_reject,
    // Strobes issued and their recognition
    input wire logic [3:0] i_conn_issue,
    input wire logic [3:0] i_func_issue,
    input wire logic [3:0] i_conn_ack,
    input wire logic [3:0] i_func_ack,
    // Busy per channel
    output logic [3:0] o_busy
);
    logic [3:0] conn_pend_ff;
    logic [3:0] func_pend_ff;

    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : g_ch
            // A new strobe in the ack cycle keeps the channel pending
            wire nxt_conn = i_conn_issue[c] |
                            (conn_pend_ff[c] & ~i_conn_ack[c]);
            wire nxt_func = i_func_issue[c] |
                            (func_pend_ff[c] & ~i_func_ack[c]);
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    conn_pend_ff[c] <= 1'b0;
                    func_pend_ff[c] <= 1'b0;
                end else if (i_ce) begin
                    conn_pend_ff[c] <= nxt_conn;
                    func_pend_ff[c] <= nxt_func;
                end
            end
            assign o_busy[c] = i_writing[c] | i_reading[c] |
                               i_reject[c] | conn_pend_ff[c] |
                               func_pend_ff[c];
        end
    endgenerate
endmodule

/* File: iosic_flags.sv */
`timescale 1ns/1ps
module iosic_flags (
    // Clock and control
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Set and clear per bit
    input wire logic [11:0] i_set,
    input wire logic [11:0] i_clr,
    // Flag state
    output logic [11:0] o_flags
);
    logic [11:0] flags_ff;

    genvar b;
    generate
        for (b = 0; b < 12; b = b + 1) begin : g_bit
            // Set wins so an event in the clear cycle is kept
            wire nxt_flag = i_set[b] | (flags_ff[b] & ~i_clr[b]);
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    flags_ff[b] <= 1'b0;
                end else if (i_ce) begin
                    flags_ff[b] <= nxt_flag;
                end
            end
        end
    endgenerate

    assign o_flags = flags_ff;
endmodule

/* File: iosic_ctrl.sv */
// Functional notes
// - Busy: writing, reading, reject, or connect/function not yet recognized.
// - Connect: busy gives reject at P+1, else code plus connect strobe, P+2.
// - Function select: same busy check; code plus function strobe, P+2.
// - Four channels, designator 0 to 3, for all channel commands.
// - External copy: status low 12 bits, mask high 12 bits, P+1.
// - Internal copy: internal status low, mask high, then P+1.
// - Subcodes 2 and 3: zero code copies, nonzero code senses.
// - Interrupt sense: any match continues P+1, none skips to P+2.
// - Sense bits 00-03 are channel lines, 08-11 internal conditions.
// - Internal flag clears when an interrupt sense senses it.
// - Bits: 08 clock, 09 exponent/decimal, 10 arithmetic, 11 search.
// - Flag clear clears selected internal flags, never external lines.
// - Mask bits 00-07 enable channel 0-7 interrupts, internal and external.
// - Mask set: ones in code set mask bits, others unchanged.
// - Mask clear: ones in code clear mask bits, others unchanged.
// - Peer signal stays asserted until the peer processor recognizes it.
// - Float fault force sets its flip-flop, raising bit 09.
// - Decimal fault force sets its flip-flop on the bit 09 path.
// - Gate off disables interrupt control.
// - Gate on enables control after one further instruction executes.
`timescale 1ns/1ps
`include "iosic_params.svh"
module iosic_ctrl
    import iosic_pkg::*;
(
    // Clock, reset, clock enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Instruction from the processor
    input wire logic i_instr_valid,
    input wire logic [23:0] i_instr,
    input wire logic i_instr_retired,
    // Channel side
    input wire logic [3:0] i_ch_writing,
    input wire logic [3:0] i_ch_reading,
    input wire logic [3:0] i_ch_reject,
    input wire logic [3:0] i_ch_conn_ack,
    input wire logic [3:0] i_ch_func_ack,
    input wire logic [47:0] i_ch_ext_status,
    input wire logic [15:0] i_ch_int_lines,
    output logic [11:0] o_ch_code,
    output logic [3:0] o_ch_conn_en,
    output logic [3:0] o_ch_func_en,
    // Interrupt sources
    input wire logic [7:0] i_chan_int_set,
    input wire logic [7:0] i_chan_ext_irq,
    input wire logic i_clock_tick,
    input wire logic i_exp_ovf,
    input wire logic i_arith_ovf,
    input wire logic i_search_done,
    // Peer processor
    input wire logic i_peer_ack,
    output logic o_peer_irq,
    // Results to the processor
    output logic o_done,
    output logic o_reject,
    output logic [1:0] o_next_ofs,
    output logic o_acc_load,
    output logic [23:0] o_acc,
    // Interrupt state
    output logic [11:0] o_mask,
    output logic o_float_fault,
    output logic o_dec_fault,
    output logic o_int_gate,
    output logic o_irq
);
    wire take = i_ce & i_instr_valid;
    wire [5:0] f_op = i_instr[`IOSIC_OP_HI:`IOSIC_OP_LO];
    wire [2:0] f_sub = i_instr[`IOSIC_SUB_HI:`IOSIC_SUB_LO];
    wire [2:0] f_sub2 = i_instr[`IOSIC_SUB2_HI:`IOSIC_SUB2_LO];
    wire [1:0] ch = i_instr[`IOSIC_CH_HI:`IOSIC_CH_LO];
    wire [11:0] code = i_instr[`IOSIC_CODE_HI:`IOSIC_CODE_LO];
    wire in_group = (f_op == `IOSIC_GROUP);
    wire code_zero = (code == 12'h000);

    // Decode of the group subcodes
    wire is_g5 = in_group & (f_sub == `IOSIC_SUB_G5);
    wire is_g7 = in_group & (f_sub == `IOSIC_SUB_G7);
    wire is_ext = in_group & (f_sub == `IOSIC_SUB_EXT);
    wire is_int = in_group & (f_sub == `IOSIC_SUB_INT);
    iosic_op_t op;
    assign op =
        ~in_group ? IOSIC_OP_NONE :
        (f_sub == `IOSIC_SUB_CON) ? IOSIC_OP_CON :
        (f_sub == `IOSIC_SUB_SEL) ? IOSIC_OP_SEL :
        (is_ext & code_zero) ? IOSIC_OP_EXT_COPY :
        is_ext ? IOSIC_OP_EXT_PROBE :
        (is_int & code_zero) ? IOSIC_OP_INT_COPY :
        is_int ? IOSIC_OP_INT_PROBE :
        (f_sub == `IOSIC_SUB_SENSE) ? IOSIC_OP_INT_SENSE :
        (is_g5 & (f_sub2 == `IOSIC_G5_CLEAR)) ? IOSIC_OP_FLAG_CLEAR :
        (is_g5 & (f_sub2 == `IOSIC_G5_MSET)) ? IOSIC_OP_MSET :
        (is_g5 & (f_sub2 == `IOSIC_G5_MCLR)) ? IOSIC_OP_MCLR :
        (is_g5 & (f_sub2 == `IOSIC_G5_PEER)) ? IOSIC_OP_PEER :
        (is_g7 & (f_sub2 == `IOSIC_G7_FLOAT)) ? IOSIC_OP_FLOAT :
        (is_g7 & (f_sub2 == `IOSIC_G7_DEC)) ? IOSIC_OP_DEC :
        (is_g7 & (f_sub2 == `IOSIC_G7_OFF)) ? IOSIC_OP_GATE_OFF :
        (is_g7 & (f_sub2 == `IOSIC_G7_ON)) ? IOSIC_OP_GATE_ON :
        IOSIC_OP_NONE;

    // State
    logic [11:0] mask_ff;
    logic [11:0] ch_code_ff;
    logic [3:0] conn_en_ff;
    logic [3:0] func_en_ff;
    logic peer_ff;
    logic done_ff;
    logic reject_ff;
    logic [1:0] ofs_ff;
    logic acc_load_ff;
    logic [23:0] acc_ff;
    logic float_ff;
    logic dec_ff;
    logic gate_ff;
    logic hold_ff;
    logic irq_ff;

    // Channel busy and flags
    logic [3:0] busy;
    logic [11:0] flags;
    wire [3:0] ch_onehot = 4'h1 << ch;
    wire sel_busy = busy[ch];
    wire is_con = take & (op == IOSIC_OP_CON);
    wire is_sel = take & (op == IOSIC_OP_SEL);
    wire [3:0] conn_issue = (is_con & ~sel_busy) ? ch_onehot : 4'h0;
    wire [3:0] func_issue = (is_sel & ~sel_busy) ? ch_onehot : 4'h0;

    iosic_busy u_busy (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_writing(i_ch_writing),
        .i_reading(i_ch_reading),
        .i_reject(i_ch_reject),
        .i_conn_issue(conn_issue),
        .i_func_issue(func_issue),
        .i_conn_ack(i_ch_conn_ack),
        .i_func_ack(i_ch_func_ack),
        .o_busy(busy)
    );

    // Selected channel inputs
    wire [11:0] ext_stat = i_ch_ext_status[ch*12 +: 12];
    wire [3:0] int_lines = i_ch_int_lines[ch*4 +: 4];
    // Internal status is the live flag set
    wire [11:0] int_stat = flags;
    // Sense view: channel lines low, internal conditions high
    wire [11:0] sense_vec = {flags[11:8], 4'h0, int_lines};
    wire sense_hit = |(code & sense_vec);
    wire ext_hit = |(code & ext_stat);
    wire int_hit = |(code & int_stat);

    // Flag sets, bit 09 shared by exponent, float and decimal faults
    wire is_float = take & (op == IOSIC_OP_FLOAT);
    wire is_dec = take & (op == IOSIC_OP_DEC);
    wire [11:0] flag_set;
    assign flag_set[7:0] = i_chan_int_set;
    assign flag_set[`IOSIC_BIT_CLOCK] = i_clock_tick;
    assign flag_set[`IOSIC_BIT_EXP] =
        i_exp_ovf | is_float | is_dec;
    assign flag_set[`IOSIC_BIT_ARITH] = i_arith_ovf;
    assign flag_set[`IOSIC_BIT_SEARCH] = i_search_done;

    // Sensed internal conditions clear; external lines are not flags
    wire is_sense = take & (op == IOSIC_OP_INT_SENSE);
    wire is_fclr = take & (op == IOSIC_OP_FLAG_CLEAR);
    wire [11:0] sense_clr =
        is_sense ? {code[11:8], 8'h00} : 12'h000;
    wire [11:0] fclr_clr = is_fclr ? code : 12'h000;
    wire [11:0] flag_clr = sense_clr | fclr_clr;

    iosic_flags u_flags (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_set(flag_set),
        .i_clr(flag_clr),
        .o_flags(flags)
    );

    // Mask update
    wire is_mset = take & (op == IOSIC_OP_MSET);
    wire is_mclr = take & (op == IOSIC_OP_MCLR);
    wire [11:0] nxt_mask =
        is_mset ? (mask_ff | code) :
        is_mclr ? (mask_ff & ~code) :
        mask_ff;

    // Return offset
    wire con_or_sel = (op == IOSIC_OP_CON) | (op == IOSIC_OP_SEL);
    wire [1:0] nxt_ofs =
        con_or_sel ? (sel_busy ? `IOSIC_OFS_NEXT
                               : `IOSIC_OFS_SKIP) :
        (op == IOSIC_OP_INT_SENSE) ? (sense_hit ? `IOSIC_OFS_NEXT
                                    : `IOSIC_OFS_SKIP) :
        (op == IOSIC_OP_EXT_PROBE) ? (ext_hit ? `IOSIC_OFS_NEXT
                                    : `IOSIC_OFS_SKIP) :
        (op == IOSIC_OP_INT_PROBE) ? (int_hit ? `IOSIC_OFS_NEXT
                                    : `IOSIC_OFS_SKIP) :
        `IOSIC_OFS_NEXT;
    wire nxt_reject = con_or_sel & sel_busy;

    // Accumulator copy
    wire is_xcopy = (op == IOSIC_OP_EXT_COPY);
    wire is_icopy = (op == IOSIC_OP_INT_COPY);
    wire nxt_acc_load = take & (is_xcopy | is_icopy);
    wire [23:0] nxt_acc =
        is_xcopy ? {mask_ff, ext_stat} :
        is_icopy ? {mask_ff, int_stat} :
        acc_ff;

    // Channel code held after each issued strobe
    wire issue = (|conn_issue) | (|func_issue);
    wire [11:0] nxt_ch_code = issue ? code : ch_code_ff;

    // Peer signal: a new request in the ack cycle keeps it high
    wire is_peer = take & (op == IOSIC_OP_PEER);
    wire nxt_peer = is_peer | (peer_ff & ~i_peer_ack);

    // Fault flip-flops drop with a clear of bit 09
    wire clr_exp = flag_clr[`IOSIC_BIT_EXP];
    wire nxt_float = is_float | (float_ff & ~clr_exp);
    wire nxt_dec = is_dec | (dec_ff & ~clr_exp);

    // Interrupt gate with a one-instruction holdoff
    wire is_on = take & (op == IOSIC_OP_GATE_ON);
    wire is_off = take & (op == IOSIC_OP_GATE_OFF);
    wire nxt_gate =
        is_off ? 1'b0 :
        is_on ? 1'b1 :
        gate_ff;
    wire nxt_hold =
        is_off ? 1'b0 :
        is_on ? 1'b1 :
        (hold_ff & ~i_instr_retired);

    // Channel internal flags and external lines share mask bits 00-07
    wire [11:0] active = flags | {4'h0, i_chan_ext_irq};
    wire [11:0] pending = active & mask_ff;
    wire nxt_irq = gate_ff & ~hold_ff & (|pending);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mask_ff <= `IOSIC_MASK_RST;
            ch_code_ff <= 12'h000;
            conn_en_ff <= 4'h0;
            func_en_ff <= 4'h0;
            peer_ff <= 1'b0;
            float_ff <= 1'b0;
            dec_ff <= 1'b0;
            gate_ff <= 1'b0;
            hold_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else if (i_ce) begin
            mask_ff <= nxt_mask;
            ch_code_ff <= nxt_ch_code;
            conn_en_ff <= conn_issue;
            func_en_ff <= func_issue;
            peer_ff <= nxt_peer;
            float_ff <= nxt_float;
            dec_ff <= nxt_dec;
            gate_ff <= nxt_gate;
            hold_ff <= nxt_hold;
            irq_ff <= nxt_irq;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            done_ff <= 1'b0;
            reject_ff <= 1'b0;
            ofs_ff <= `IOSIC_OFS_NEXT;
            acc_load_ff <= 1'b0;
            acc_ff <= 24'h00_0000;
        end else if (i_ce) begin
            done_ff <= i_instr_valid;
            reject_ff <= i_instr_valid & nxt_reject;
            ofs_ff <= i_instr_valid ? nxt_ofs : ofs_ff;
            acc_load_ff <= nxt_acc_load;
            acc_ff <= nxt_acc;
        end
    end

    assign o_ch_code = ch_code_ff;
    assign o_ch_conn_en = conn_en_ff;
    assign o_ch_func_en = func_en_ff;
    assign o_peer_irq = peer_ff;
    assign o_done = done_ff;
    assign o_reject = reject_ff;
    assign o_next_ofs = ofs_ff;
    assign o_acc_load = acc_load_ff;
    assign o_acc = acc_ff;
    assign o_mask = mask_ff;
    assign o_float_fault = float_ff;
    assign o_dec_fault = dec_ff;
    assign o_int_gate = gate_ff;
    assign o_irq = irq_ff;
endmodule

/* File: iosic_periph.sv */
`timescale 1ns/1ps
module iosic_periph (
    // Clock and ack latency
    input wire logic i_clk,
    input wire logic [3:0] i_lat,
    // Strobes from the channel
    input wire logic [11:0] i_code,
    input wire logic [3:0] i_conn_en,
    input wire logic [3:0] i_func_en,
    // Recognition and decoded selection
    output logic [3:0] o_conn_ack,
    output logic [3:0] o_func_ack,
    output logic [2:0] o_ctl_sel,
    output logic [8:0] o_unit_sel
);
    logic [3:0] pend_ff = 4'h0;
    logic fn_ff = 1'b0;
    logic [3:0] cnt_ff = 4'h0;
    // A slow latency keeps the channel busy long enough to be refused
    always_ff @(posedge i_clk) begin
        o_conn_ack <= 4'h0;
        o_func_ack <= 4'h0;
        if (|(i_conn_en | i_func_en)) begin
            pend_ff <= i_conn_en | i_func_en;
            fn_ff <= |i_func_en;
            cnt_ff <= i_lat;
            if (|i_conn_en) begin
                o_ctl_sel <= i_code[11:9];
                o_unit_sel <= i_code[8:0];
            end
        end else if (cnt_ff > 4'h1) begin
            cnt_ff <= cnt_ff - 4'h1;
        end else if (cnt_ff == 4'h1) begin
            cnt_ff <= 4'h0;
            o_conn_ack <= fn_ff ? 4'h0 : pend_ff;
            o_func_ack <= fn_ff ? pend_ff : 4'h0;
        end
    end
endmodule

/* File: iosic_ctrl_chk.sv */
`timescale 1ns/1ps
`include "iosic_params.svh"
module iosic_ctrl_chk (
    // Clock and instruction
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_instr_valid,
    input wire logic [23:0] i_instr,
    input wire logic [47:0] i_ch_ext_status,
    input wire logic i_peer_ack,
    // Observed results
    input wire logic o_done,
    input wire logic o_reject,
    input wire logic [1:0] o_next_ofs,
    input wire logic [3:0] o_ch_conn_en,
    input wire logic [3:0] o_ch_func_en,
    input wire logic o_acc_load,
    input wire logic [23:0] o_acc,
    input wire logic [11:0] o_mask,
    input wire logic o_float_fault,
    input wire logic o_int_gate,
    input wire logic o_peer_irq,
    input wire logic o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic take = i_ce && i_instr_valid;
    wire logic [11:0] op = i_instr[23:12];
    wire logic [11:0] ext_sel = i_ch_ext_status[12*i_instr[13:12] +: 12];
    done_exact_a: assert property ($past(i_ce) |->
        o_done == $past(take)) else $error("done pulse misplaced");
    conn_strobe_a: assert property (|o_ch_conn_en && $past(i_ce) |->
        o_done && !o_reject && o_next_ofs == `IOSIC_OFS_SKIP
        && o_ch_conn_en == 4'(4'h1 << $past(i_instr[13:12])))
        else $error("connect strobe wrong");
    func_strobe_a: assert property (|o_ch_func_en && $past(i_ce) |->
        $past(i_instr[17:15]) == `IOSIC_SUB_SEL
        && o_ch_func_en == 4'(4'h1 << $past(i_instr[13:12])))
        else $error("function strobe wrong");
    reject_ofs_a: assert property (o_reject |-> o_done
        && o_next_ofs == `IOSIC_OFS_NEXT && o_ch_conn_en == 4'h0
        && o_ch_func_en == 4'h0) else $error("reject path wrong");
    mask_set_a: assert property (take && op ==
        {`IOSIC_GROUP, `IOSIC_SUB_G5, `IOSIC_G5_MSET} |=>
        o_mask == ($past(o_mask) | $past(i_instr[11:0])))
        else $error("mask set wrong");
    mask_clr_a: assert property (take && op ==
        {`IOSIC_GROUP, `IOSIC_SUB_G5, `IOSIC_G5_MCLR} |=>
        o_mask == ($past(o_mask) & ~$past(i_instr[11:0])))
        else $error("mask clear wrong");
    peer_hold_a: assert property (o_peer_irq && !i_peer_ack |=>
        o_peer_irq) else $error("peer interrupt dropped early");
    irq_gated_a: assert property (o_irq && $past(i_ce) |->
        $past(o_int_gate) && |$past(o_mask))
        else $error("interrupt without gate or mask");
    ext_copy_a: assert property (take && i_instr[11:0] == 12'h000
        && op[11:3] == {`IOSIC_GROUP, `IOSIC_SUB_EXT} |=> o_acc_load
        && o_acc == {$past(o_mask), $past(ext_sel)})
        else $error("external copy wrong");
    float_set_a: assert property (take && op ==
        {`IOSIC_GROUP, `IOSIC_SUB_G7, `IOSIC_G7_FLOAT} |=> o_float_fault)
        else $error("float fault not set");
    gate_off_a: assert property (take && op ==
        {`IOSIC_GROUP, `IOSIC_SUB_G7, `IOSIC_G7_OFF} |=> !o_int_gate)
        else $error("gate still on");
endmodule
bind iosic_ctrl iosic_ctrl_chk chk (.i_clk, .i_rst, .i_ce, .i_instr_valid,
    .i_instr, .i_ch_ext_status, .i_peer_ack, .o_done, .o_reject, .o_next_ofs,
    .o_ch_conn_en, .o_ch_func_en, .o_acc_load, .o_acc, .o_mask,
    .o_float_fault, .o_int_gate, .o_peer_irq, .o_irq);

/* File: iosic_ctrl_bench.sv */
`timescale 1ns/1ps
`include "iosic_params.svh"
module iosic_ctrl_bench;
    typedef struct packed {
        logic [1:0] ofs;
        logic rej;
        logic ld;
        logic [23:0] acc;
    } iosic_exp_t;
    localparam logic [2:0] CON = `IOSIC_SUB_CON, SEL = `IOSIC_SUB_SEL,
        EXT = `IOSIC_SUB_EXT, INT = `IOSIC_SUB_INT, SNS = `IOSIC_SUB_SENSE,
        G5 = `IOSIC_SUB_G5, G7 = `IOSIC_SUB_G7;
    iosic_exp_t exp_q[$];
    iosic_exp_t e;
    logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_instr_valid = 1'b0;
    logic [23:0] i_instr = '0;
    logic i_instr_retired = 1'b0, i_peer_ack = 1'b0, i_clock_tick = 1'b0;
    logic i_exp_ovf = 1'b0, i_arith_ovf = 1'b0, i_search_done = 1'b0;
    logic [3:0] i_ch_writing = '0, i_ch_reading = '0, i_ch_reject = '0;
    logic [47:0] i_ch_ext_status = '0;
    logic [15:0] i_ch_int_lines = '0;
    logic [7:0] i_chan_int_set = '0, i_chan_ext_irq = '0;
    wire logic [3:0] i_ch_conn_ack, i_ch_func_ack;
    logic [3:0] o_ch_conn_en, o_ch_func_en, lat = 4'h6;
    logic [11:0] o_ch_code, o_mask, mx, mc, m, st;
    logic [1:0] o_next_ofs;
    logic [23:0] o_acc;
    logic [2:0] ctl;
    logic [8:0] unit;
    logic o_peer_irq, o_done, o_reject, o_acc_load;
    logic o_float_fault, o_dec_fault, o_int_gate, o_irq;
    integer seed = 49822;
    int bad_count = 0, check_count = 0, cyc = 0, c;
    iosic_ctrl dut (.i_clk, .i_rst, .i_ce, .i_instr_valid, .i_instr,
        .i_instr_retired, .i_ch_writing, .i_ch_reading, .i_ch_reject,
        .i_ch_conn_ack, .i_ch_func_ack, .i_ch_ext_status, .i_ch_int_lines,
        .o_ch_code, .o_ch_conn_en, .o_ch_func_en, .i_chan_int_set,
        .i_chan_ext_irq, .i_clock_tick, .i_exp_ovf, .i_arith_ovf,
        .i_search_done, .i_peer_ack, .o_peer_irq, .o_done, .o_reject,
        .o_next_ofs, .o_acc_load, .o_acc, .o_mask, .o_float_fault,
        .o_dec_fault, .o_int_gate, .o_irq);
    iosic_periph far (.i_clk, .i_lat(lat), .i_code(o_ch_code),
        .i_conn_en(o_ch_conn_en), .i_func_en(o_ch_func_en),
        .o_conn_ack(i_ch_conn_ack), .o_func_ack(i_ch_func_ack),
        .o_ctl_sel(ctl), .o_unit_sel(unit));
    initial forever #25 i_clk = ~i_clk;
    task automatic chkv(input string nm, input logic [23:0] ex, got);
        check_count++;
        if (got !== ex) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic chk1(input string nm, input logic ex, got);
        check_count++;
        if (got !== ex) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", nm, ex, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic issue(input logic [2:0] s, f, input logic [11:0] x,
            input logic [1:0] o, input logic r, l, input logic [23:0] a);
        @(negedge i_clk);
        i_instr = {`IOSIC_GROUP, s, f, x};
        i_instr_valid = 1'b1;
        exp_q.push_back({o, r, l, a});
        @(negedge i_clk);
        i_instr_valid = 1'b0;
    endtask
    task automatic op(input logic [2:0] s, f, input logic [11:0] x,
            input logic [1:0] o);
        issue(s, f, x, o, 1'b0, 1'b0, '0);
    endtask
    always @(posedge i_clk) begin
        #1;
        if (o_done === 1'b1) begin
            if (exp_q.size() == 0)
                chk1("spare done", 1'b0, 1'b1);
            else begin
                e = exp_q.pop_front();
                chkv("next ofs", 24'(e.ofs), 24'(o_next_ofs));
                chk1("reject", e.rej, o_reject);
                chk1("acc load", e.ld, o_acc_load);
                if (e.ld)
                    chkv("acc", e.acc, o_acc);
            end
        end
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        chkv("mask", 24'(`IOSIC_MASK_RST), 24'(o_mask));
        chk1("gate", 1'b0, o_int_gate);
        mx = 12'($random(seed));
        mc = 12'($random(seed));
        op(G5, `IOSIC_G5_MSET, mx, 2'h1);
        op(G5, `IOSIC_G5_MCLR, mc, 2'h1);
        m = mx & ~mc;
        for (c = 0; c < 4; c++) begin
            st = 12'($random(seed));
            i_ch_ext_status[c*12 +: 12] = st;
            issue(EXT, 3'(c), 12'h000, 2'h1, 1'b0, 1'b1, {m, st});
        end
        op(EXT, 3'h3, ~st, 2'h2);
        op(CON, 3'h1, 12'hA35, 2'h2);
        chkv("conn en", 24'(4'h2), 24'(o_ch_conn_en));
        chkv("code", 24'(12'hA35), 24'(o_ch_code));
        issue(CON, 3'h1, 12'h001, 2'h1, 1'b1, 1'b0, '0);
        chkv("ctl", 24'(3'h5), 24'(ctl));
        chkv("unit", 24'(9'h035), 24'(unit));
        repeat (10) @(negedge i_clk);
        op(SEL, 3'h1, 12'h077, 2'h2);
        chkv("func en", 24'(4'h2), 24'(o_ch_func_en));
        repeat (10) @(negedge i_clk);
        for (c = 0; c < 3; c++) begin
            i_ch_writing[2] = (c == 0);
            i_ch_reading[2] = (c == 1);
            i_ch_reject[2] = (c == 2);
            issue(SEL, 3'h2, 12'h010, 2'h1, 1'b1, 1'b0, '0);
        end
        i_ch_reject = '0;
        lat = 4'h1;
        op(SEL, 3'h2, 12'h010, 2'h2);
        repeat (4) @(negedge i_clk);
        op(CON, 3'h2, 12'h010, 2'h2);
        {i_search_done, i_arith_ovf, i_exp_ovf, i_clock_tick} = 4'hF;
        @(negedge i_clk);
        {i_search_done, i_arith_ovf, i_exp_ovf, i_clock_tick} = 4'h0;
        issue(INT, 3'h0, 12'h000, 2'h1, 1'b0, 1'b1, {m, 12'hF00});
        op(SNS, 3'h0, 12'h100, 2'h1);
        op(SNS, 3'h0, 12'h100, 2'h2);
        op(G5, `IOSIC_G5_CLEAR, 12'hE00, 2'h1);
        issue(INT, 3'h0, 12'h000, 2'h1, 1'b0, 1'b1, {m, 12'h000});
        i_ch_int_lines = 16'h00F4;
        op(SNS, 3'h0, 12'h0FB, 2'h2);
        op(SNS, 3'h0, 12'h004, 2'h1);
        op(SNS, 3'h1, 12'h001, 2'h1);
        i_chan_int_set[3] = 1'b1;
        i_chan_ext_irq[5] = 1'b1;
        @(negedge i_clk);
        i_chan_int_set[3] = 1'b0;
        issue(INT, 3'h0, 12'h000, 2'h1, 1'b0, 1'b1, {m, 12'h008});
        op(G5, `IOSIC_G5_CLEAR, 12'h028, 2'h1);
        issue(INT, 3'h0, 12'h000, 2'h1, 1'b0, 1'b1, {m, 12'h000});
        // Let the last done pulse drop before freezing, or it would repeat
        @(negedge i_clk);
        i_ce = 1'b0;
        i_instr = {`IOSIC_GROUP, G5, `IOSIC_G5_MSET, 12'hFFF};
        {i_instr_valid, i_clock_tick} = 2'b11;
        repeat (3) @(negedge i_clk);
        {i_ce, i_instr_valid, i_clock_tick} = 3'b100;
        chkv("frozen mask", 24'(m), 24'(o_mask));
        op(G7, `IOSIC_G7_FLOAT, 12'h000, 2'h1);
        chk1("float", 1'b1, o_float_fault);
        op(G7, `IOSIC_G7_DEC, 12'h000, 2'h1);
        chk1("dec", 1'b1, o_dec_fault);
        issue(INT, 3'h0, 12'h000, 2'h1, 1'b0, 1'b1, {m, 12'h200});
        op(SNS, 3'h0, 12'h200, 2'h1);
        op(G7, 3'h5, 12'h000, 2'h1);
        op(G5, `IOSIC_G5_PEER, 12'h000, 2'h1);
        repeat (4) @(negedge i_clk);
        chk1("peer", 1'b1, o_peer_irq);
        i_peer_ack = 1'b1;
        @(negedge i_clk);
        i_peer_ack = 1'b0;
        @(negedge i_clk);
        chk1("peer", 1'b0, o_peer_irq);
        op(G5, `IOSIC_G5_MCLR, 12'hFFF, 2'h1);
        op(G5, `IOSIC_G5_MSET, 12'h020, 2'h1);
        op(G7, `IOSIC_G7_ON, 12'h000, 2'h1);
        repeat (3) @(negedge i_clk);
        chk1("gate", 1'b1, o_int_gate);
        chk1("irq", 1'b0, o_irq);
        i_instr_retired = 1'b1;
        @(negedge i_clk);
        i_instr_retired = 1'b0;
        @(negedge i_clk);
        chk1("irq", 1'b1, o_irq);
        op(G7, `IOSIC_G7_OFF, 12'h000, 2'h1);
        @(negedge i_clk);
        chk1("irq", 1'b0, o_irq);
        repeat (3) @(negedge i_clk);
        chkv("pending", 24'h0, 24'(exp_q.size()));
        stop_test();
    end
endmodule
